// >>> verilog/boot_pkg.sv
package boot_pkg;
   // Clock and serial timing
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned BAUD_RATE    = 9600;
   localparam int unsigned BIT_CYCLES   = CLK_HZ / BAUD_RATE;
   localparam int unsigned CYC_W        = 13;

   // Serial image layout
   localparam logic [7:0]  IMAGE_MAX    = 8'hFE;
   localparam logic [7:0]  IDX_COUNT    = 8'h00;
   localparam logic [7:0]  IDX_FIRST    = 8'h01;
   localparam logic [7:0]  ONE_BYTE     = 8'h01;

   // Addresses
   localparam logic [15:0] START_PC        = 16'h0081;
   localparam logic [15:0] PSEUDO_VEC_BASE = 16'h0083;
   localparam logic [15:0] PSEUDO_VEC_STEP = 16'h0003;
   localparam logic [15:0] BOOT_VEC_BASE   = 16'h3FE4;
   localparam logic [15:0] BOOT_VEC_TOP    = 16'h3FEF;
   localparam logic [15:0] USER_VEC_TOP    = 16'h3FFF;
   localparam logic [15:0] WORD_ONE        = 16'h0001;
   localparam logic [7:0]  JUMP_OPCODE     = 8'hCC;

   // External copy
   localparam int unsigned CA_W         = 14;
   localparam logic [13:0] COPY_FIRST   = 14'h0000;
   localparam logic [7:0]  SETTLE_RESET = 8'h04;

   // Vector selects
   localparam logic [2:0]  VEC_SWI      = 3'h0;
   localparam logic [2:0]  VEC_IRQ      = 3'h1;
   localparam logic [2:0]  VEC_RESET    = 3'h5;

   // Register offsets
   localparam logic [3:0]  REG_STATUS   = 4'h0;
   localparam logic [3:0]  REG_COUNT    = 4'h1;
   localparam logic [3:0]  REG_RAM_PTR  = 4'h2;
   localparam logic [3:0]  REG_RAM_DATA = 4'h3;
   localparam logic [3:0]  REG_SETTLE   = 4'h4;
   localparam logic [3:0]  REG_OPCODE   = 4'h5;

   typedef enum logic [2:0]
   {
      MODE_SINGLE  = 3'b000,
      MODE_VERIFY  = 3'b001,
      MODE_PROGVER = 3'b010,
      MODE_RAMJMP  = 3'b011,
      MODE_RAMLOAD = 3'b100
   } mode_t;

   typedef enum logic [1:0]
   {
      LD_IDLE  = 2'b00,
      LD_COUNT = 2'b01,
      LD_DATA  = 2'b10,
      LD_DONE  = 2'b11
   } load_state_t;

   typedef enum logic [2:0]
   {
      EP_IDLE   = 3'b000,
      EP_CLEAR  = 3'b001,
      EP_SETTLE = 3'b010,
      EP_SAMPLE = 3'b011,
      EP_STEP   = 3'b100,
      EP_DONE   = 3'b101
   } copy_state_t;
endpackage : boot_pkg

// >>> verilog/rx_byte_if.sv
`timescale 1ns/1ps
interface rx_byte_if;
   logic       valid;
   logic [7:0] data;
   logic       frame_err;
   modport src (output valid, output data, output frame_err);
   modport snk (input valid, input data, input frame_err);
endinterface : rx_byte_if

// >>> verilog/serial_byte_receiver.sv
`timescale 1ns/1ps
module serial_byte_receiver
   import boot_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYCLES
)
(
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic serial_load_pin_i,
   rx_byte_if.src    rx
);
   localparam logic [CYC_W-1:0] FULL_BIT = CYC_W'(BIT_CYC - 1);
   localparam logic [CYC_W-1:0] HALF_BIT = CYC_W'(BIT_CYC / 2);
   localparam logic [3:0]       LAST_BIT = 4'h7;

   logic [CYC_W-1:0] cyc_q;
   logic [3:0]       bit_q;
   logic [7:0]       shift_q;
   logic [1:0]       phase_q;   // 0 idle, 1 start, 2 data, 3 stop

   // Mid-bit sampling, LSB first, stop bit checked
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         cyc_q        <= '0;
         bit_q        <= '0;
         shift_q      <= '0;
         phase_q      <= 2'h0;
         rx.valid     <= 1'b0;
         rx.data      <= '0;
         rx.frame_err <= 1'b0;
      end
      else
      begin
         rx.valid     <= 1'b0;
         rx.frame_err <= 1'b0;
         case (phase_q)
            2'h0:
            begin
               cyc_q <= '0;
               if (!serial_load_pin_i)
                  phase_q <= 2'h1;
            end
            2'h1:
            begin
               if (cyc_q == HALF_BIT)
               begin
                  cyc_q   <= '0;
                  bit_q   <= '0;
                  phase_q <= serial_load_pin_i ? 2'h0 : 2'h2;  // Glitch, not a start
               end
               else
                  cyc_q <= cyc_q + 1'b1;
            end
            2'h2:
            begin
               if (cyc_q == FULL_BIT)
               begin
                  cyc_q   <= '0;
                  shift_q <= {serial_load_pin_i, shift_q[7:1]};
                  bit_q   <= bit_q + 1'b1;
                  if (bit_q == LAST_BIT)
                     phase_q <= 2'h3;
               end
               else
                  cyc_q <= cyc_q + 1'b1;
            end
            default:
            begin
               if (cyc_q == FULL_BIT)
               begin
                  cyc_q        <= '0;
                  phase_q      <= 2'h0;
                  rx.valid     <= serial_load_pin_i;
                  rx.frame_err <= !serial_load_pin_i;
                  rx.data      <= shift_q;
               end
               else
                  cyc_q <= cyc_q + 1'b1;
            end
         endcase
      end
   end

   a_stop_gate : assert property (@(posedge clk_i) disable iff (!resetn_i)
      rx.valid |-> !rx.frame_err && $past(serial_load_pin_i))
      else $error("byte accepted without high stop bit");
endmodule : serial_byte_receiver

// >>> verilog/boot_mode_and_bootloader.sv
// Notes on behaviour
// - Normal entry pin level selects single-chip
// - Entry plus high strap high: RAM loader
// - Low strap low: start at 0081
// - Low strap high: serial load, run 0081
// - First byte is count, length plus one
// - Image including count capped at 254
// - Frames 9600 baud, 8N1
// - Loader modes use three-byte RAM pseudo-vectors
// - Pseudo-vectors at 0083,0086,0089,008C,008F
// - EPROM loader fetches vectors 3FE4-3FEF
// - Drive external 14-bit counter clock, reset
// - Full program pass, then verify pass
// - Program indicator on during programming pass
// - Verify indicator only on exact match
// - Bus clock is oscillator divided by two
// - Reset low forces known start state
// - Straps 00 verify,01 program_indicator,10 jump,11 load
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module boot_mode_and_bootloader
   import boot_pkg::*;
#(
   parameter int unsigned    BIT_CYC    = BIT_CYCLES,
   parameter logic [13:0]    COPY_LAST  = 14'h3FFF,
   parameter logic [13:0]    EPROM_LO   = 14'h2000,
   parameter logic [13:0]    EPROM_HI   = 14'h3FDF
)
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        mode_entry_interrupt_pin_i,
   input  wire logic        boot_select_high_strap_i,
   input  wire logic        boot_select_low_strap_i,
   input  wire logic        serial_load_pin_i,
   input  wire logic [7:0]  ext_data_i,
   input  wire logic [2:0]  vec_sel_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   output logic             bus_clk_o,
   output logic             ext_cnt_clk_o,
   output logic             ext_cnt_rst_o,
   output logic             program_indicator_pin_o,
   output logic             verify_indicator_pin_o,
   output logic      [15:0] vec_addr_o,
   output logic      [15:0] start_pc_o,
   output logic             run_o
);
   rx_byte_if rx ();

   mode_t       mode_q;
   logic        started_q;
   load_state_t ld_q;
   logic [7:0]  ram_q [0:255];
   logic [7:0]  idx_q;
   logic [7:0]  left_q;
   logic        frame_err_q;
   logic [7:0]  ram_ptr_q;
   logic [7:0]  settle_q;
   copy_state_t cp_q;
   logic        pass_verify_q;
   logic [13:0] copy_addr_q;
   logic [7:0]  wait_q;
   logic        mismatch_q;
   logic [7:0]  eprom_q [0:16383];
   logic        in_range;
   logic        miss_now;
   logic [7:0]  count_clamped;

   serial_byte_receiver #(.BIT_CYC(BIT_CYC)) u_rx
   (
      .clk_i             (clk_i),
      .resetn_i          (resetn_i),
      .serial_load_pin_i (serial_load_pin_i),
      .rx                (rx)
   );

   // Strap decode into a boot mode
   function automatic mode_t decode_mode(input logic entry, input logic hi, input logic lo);
      mode_t m;
      m = MODE_SINGLE;
      if (entry)
      begin
         case ({hi, lo})
            2'b00:   m = MODE_VERIFY;
            2'b01:   m = MODE_PROGVER;
            2'b10:   m = MODE_RAMJMP;
            default: m = MODE_RAMLOAD;
         endcase
      end
      return m;
   endfunction : decode_mode

   // Vector fetch address for each boot mode
   function automatic logic [15:0] vector_addr(input mode_t m, input logic [2:0] s);
      logic [15:0] a;
      a = 16'(USER_VEC_TOP - WORD_ONE - 16'({s, 1'b0}));
      if (m == MODE_RAMJMP || m == MODE_RAMLOAD)
         a = (s == VEC_RESET) ? START_PC : 16'(PSEUDO_VEC_BASE + 16'(16'(s) * PSEUDO_VEC_STEP));
      else if (m == MODE_VERIFY || m == MODE_PROGVER)
         a = 16'(BOOT_VEC_TOP - WORD_ONE - 16'({s, 1'b0}));
      return a;
   endfunction : vector_addr

   // Mode capture on the first cycle after reset release
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         mode_q    <= MODE_SINGLE;
         started_q <= 1'b0;
      end
      else if (!started_q)
      begin
         started_q <= 1'b1;
         mode_q    <= decode_mode(mode_entry_interrupt_pin_i, boot_select_high_strap_i,
                                  boot_select_low_strap_i);
      end
   end

   // Bus clock at half the input clock
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         bus_clk_o <= 1'b0;
      else
         bus_clk_o <= !bus_clk_o;
   end

   // Count byte clamp so the image never passes the stack reserve
   assign count_clamped = (rx.data > IMAGE_MAX) ? IMAGE_MAX : rx.data;

   // Serial loader: count byte then count minus one data bytes
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         ld_q        <= LD_IDLE;
         idx_q       <= IDX_COUNT;
         left_q      <= '0;
         frame_err_q <= 1'b0;
      end
      else
      begin
         if (rx.frame_err)
            frame_err_q <= 1'b1;
         case (ld_q)
            LD_IDLE:
               if (started_q && mode_q == MODE_RAMLOAD)
                  ld_q <= LD_COUNT;
            LD_COUNT:
               if (rx.valid)
               begin
                  idx_q  <= IDX_FIRST;
                  left_q <= 8'(count_clamped - ONE_BYTE);
                  ld_q   <= (count_clamped <= ONE_BYTE) ? LD_DONE : LD_DATA;
               end
            LD_DATA:
               if (rx.valid)
               begin
                  idx_q  <= idx_q + 1'b1;
                  left_q <= left_q - 1'b1;
                  if (left_q == ONE_BYTE)
                     ld_q <= LD_DONE;
               end
            default:
               ld_q <= LD_DONE;
         endcase
      end
   end

   // Loader RAM image, offset zero holds the count byte
   always_ff @(posedge clk_i)
   begin
      if (rx.valid && (ld_q == LD_COUNT || ld_q == LD_DATA))
         ram_q[idx_q] <= (ld_q == LD_COUNT) ? count_clamped : rx.data;
   end

   // Copy helpers: user EPROM window and running compare result
   assign in_range = (copy_addr_q >= EPROM_LO) && (copy_addr_q <= EPROM_HI);
   assign miss_now = mismatch_q | (in_range && (eprom_q[copy_addr_q] != ext_data_i));

   // External counter sequencing, program pass then verify pass
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         cp_q                    <= EP_IDLE;
         pass_verify_q           <= 1'b0;
         copy_addr_q             <= COPY_FIRST;
         wait_q                  <= '0;
         mismatch_q              <= 1'b0;
         ext_cnt_clk_o           <= 1'b0;
         ext_cnt_rst_o           <= 1'b0;
         program_indicator_pin_o <= 1'b0;
         verify_indicator_pin_o  <= 1'b0;
      end
      else
      begin
         case (cp_q)
            EP_IDLE:
               if (started_q && (mode_q == MODE_PROGVER || mode_q == MODE_VERIFY))
               begin
                  pass_verify_q           <= (mode_q == MODE_VERIFY);
                  program_indicator_pin_o <= (mode_q == MODE_PROGVER);
                  cp_q                    <= EP_CLEAR;
               end
            EP_CLEAR:
            begin
               ext_cnt_rst_o <= 1'b1;
               copy_addr_q   <= COPY_FIRST;
               wait_q        <= '0;
               cp_q          <= EP_SETTLE;
            end
            EP_SETTLE:
            begin
               ext_cnt_rst_o <= 1'b0;
               ext_cnt_clk_o <= 1'b0;
               wait_q        <= wait_q + 1'b1;
               if (wait_q >= settle_q)
                  cp_q <= EP_SAMPLE;
            end
            EP_SAMPLE:
            begin
               if (pass_verify_q)
                  mismatch_q <= miss_now;
               if (copy_addr_q == COPY_LAST)
               begin
                  if (!pass_verify_q)
                  begin
                     pass_verify_q           <= 1'b1;
                     program_indicator_pin_o <= 1'b0;
                     cp_q                    <= EP_CLEAR;
                  end
                  else
                  begin
                     verify_indicator_pin_o <= !miss_now;
                     cp_q                   <= EP_DONE;
                  end
               end
               else
               begin
                  ext_cnt_clk_o <= 1'b1;
                  copy_addr_q   <= copy_addr_q + 1'b1;
                  wait_q        <= '0;
                  cp_q          <= EP_STEP;
               end
            end
            EP_STEP:
            begin
               ext_cnt_clk_o <= 1'b0;
               cp_q          <= EP_SETTLE;
            end
            default:
               cp_q <= EP_DONE;
         endcase
      end
   end

   // On-chip EPROM array written only during the program pass
   always_ff @(posedge clk_i)
   begin
      if (cp_q == EP_SAMPLE && !pass_verify_q && in_range)
         eprom_q[copy_addr_q] <= ext_data_i;
   end

   // Start address, run release and vector fetch address
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         start_pc_o <= START_PC;
         run_o      <= 1'b0;
         vec_addr_o <= START_PC;
      end
      else
      begin
         start_pc_o <= vector_addr(mode_q, VEC_RESET);
         vec_addr_o <= vector_addr(mode_q, vec_sel_i);
         case (mode_q)
            MODE_RAMLOAD:             run_o <= started_q && (ld_q == LD_DONE);
            MODE_VERIFY, MODE_PROGVER: run_o <= (cp_q == EP_DONE);
            default:                  run_o <= started_q;
         endcase
      end
   end

   // Register port: settle time and RAM read pointer writable
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         settle_q  <= SETTLE_RESET;
         ram_ptr_q <= '0;
      end
      else if (reg_wr_i && reg_addr_i == REG_SETTLE)
         settle_q <= reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == REG_RAM_PTR)
         ram_ptr_q <= reg_wdata_i;
      else if (reg_rd_i && reg_addr_i == REG_RAM_DATA)
         ram_ptr_q <= ram_ptr_q + 1'b1;                                 // Auto-advance on read
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i || !reg_rd_i)
         reg_rdata_o <= '0;
      else if (reg_addr_i == REG_STATUS)
         reg_rdata_o <= {program_indicator_pin_o, verify_indicator_pin_o, frame_err_q,
                         (ld_q == LD_DONE), (cp_q == EP_DONE), mode_q};
      else if (reg_addr_i == REG_COUNT)
         reg_rdata_o <= idx_q;
      else if (reg_addr_i == REG_RAM_PTR)
         reg_rdata_o <= ram_ptr_q;
      else if (reg_addr_i == REG_RAM_DATA)
         reg_rdata_o <= ram_q[ram_ptr_q];
      else if (reg_addr_i == REG_SETTLE)
         reg_rdata_o <= settle_q;
      else if (reg_addr_i == REG_OPCODE)
         reg_rdata_o <= JUMP_OPCODE;
      else
         reg_rdata_o <= '0;
   end

   sequence s_release;
      !started_q && resetn_i;
   endsequence

   a_mode_single : assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_release and !mode_entry_interrupt_pin_i |=> mode_q == MODE_SINGLE)
      else $error("normal entry did not give single-chip");
   a_mode_ramload : assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_release and mode_entry_interrupt_pin_i && boot_select_high_strap_i && boot_select_low_strap_i
      |=> mode_q == MODE_RAMLOAD)
      else $error("straps 11 did not give RAM load");
   a_ram_jump : assert property (@(posedge clk_i) disable iff (!resetn_i)
      started_q && mode_q == MODE_RAMJMP |=> run_o && start_pc_o == START_PC)
      else $error("RAM jump did not start at 0081");
   a_image_cap : assert property (@(posedge clk_i) disable iff (!resetn_i)
      idx_q <= IMAGE_MAX)
      else $error("image passed 254 bytes");
   a_pseudo_irq : assert property (@(posedge clk_i) disable iff (!resetn_i)
      (mode_q == MODE_RAMLOAD || mode_q == MODE_RAMJMP) && vec_sel_i == VEC_IRQ && $stable(mode_q)
      |=> vec_addr_o == 16'h0086)
      else $error("external interrupt pseudo-vector wrong");
   a_boot_vec : assert property (@(posedge clk_i) disable iff (!resetn_i)
      mode_q == MODE_PROGVER && $stable(mode_q) |=> vec_addr_o >= BOOT_VEC_BASE && vec_addr_o <= BOOT_VEC_TOP)
      else $error("EPROM loader vector outside reserved ROM");
   a_cnt_pulse : assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(ext_cnt_clk_o) |=> !ext_cnt_clk_o ##1 !ext_cnt_clk_o)
      else $error("counter clock pulse too long");
   a_program_indicator_only : assert property (@(posedge clk_i) disable iff (!resetn_i)
      program_indicator_pin_o |-> !pass_verify_q && !verify_indicator_pin_o)
      else $error("program indicator outside programming pass");
   a_verify_match : assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(verify_indicator_pin_o) |-> !mismatch_q && cp_q == EP_DONE)
      else $error("verify indicator despite mismatch");
   a_bus_half : assert property (@(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i) |-> bus_clk_o != $past(bus_clk_o))
      else $error("bus clock not half rate");
endmodule : boot_mode_and_bootloader

// >>> dv/boot_source_model.sv
`timescale 1ns/1ps
module boot_source_model
#(
   parameter int BIT = 16
)
(
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic [7:0]  byte_i,
   input  wire logic        bad_stop_i,
   input  wire logic        flip_i,
   input  wire logic        ext_cnt_clk_i,
   input  wire logic        ext_cnt_rst_i,
   output logic             line_o,
   output logic             busy_o,
   output logic      [7:0]  ext_data_o
);
   logic [9:0]  sh_q = 10'h3FF;
   logic [3:0]  nb_q = 4'h0;
   int          bc_q = 0;
   logic [13:0] cnt_q = 14'h0000;

   // External address counter clears and steps only when told
   always_ff @(posedge clk_i)
      if (ext_cnt_rst_i) cnt_q <= 14'h0000;
      else if (ext_cnt_clk_i) cnt_q <= cnt_q + 14'h0001;

   // Image is stored at the device's own addresses; flip corrupts one byte
   assign ext_data_o = (cnt_q[7:0] * 8'h25 + 8'h5A) ^ {5'h00, flip_i && cnt_q == 14'h0006, 2'h0};

   // Frame sender: start low, eight bits LSB first, stop bit, idle high
   always_ff @(posedge clk_i)
      if (nb_q == 4'h0 && go_i)
      begin
         sh_q <= {~bad_stop_i, byte_i, 1'b0};
         nb_q <= 4'hA;
         bc_q <= BIT;
      end
      else if (nb_q != 4'h0 && bc_q == 1)
      begin
         sh_q <= {1'b1, sh_q[9:1]};
         nb_q <= nb_q - 4'h1;
         bc_q <= BIT;
      end
      else if (nb_q != 4'h0)
         bc_q <= bc_q - 1;

   assign line_o = (nb_q == 4'h0) ? 1'b1 : sh_q[0];
   assign busy_o = nb_q != 4'h0;
endmodule : boot_source_model

// >>> dv/boot_mode_and_bootloader_tb.sv
`timescale 1ns/1ps
module boot_mode_and_bootloader_tb;
   import boot_pkg::*;
   localparam int BIT = 16;
   logic        clk = 0, resetn = 0, entry = 0, hi = 0, lo = 0, wr = 0, rd = 0;
   logic        go = 0, bad = 0, flip = 0, rd_seen = 0, b0;
   logic [2:0]  vec_sel = 3'h0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00, tx_byte = 8'h00, rdata, ext_data, a_b, b_b;
   logic        bus_clk, cclk, crst, program_indicator, verify_indicator, run, line, busy;
   logic [15:0] vaddr, spc;
   logic [7:0]  qexp[$];
   int          err_total = 0, checks_done = 0, seed = 32'he24da310;

   initial forever #12.5 clk = ~clk;

   boot_mode_and_bootloader #(.BIT_CYC(BIT), .COPY_LAST(14'h000F), .EPROM_LO(14'h0004), .EPROM_HI(14'h000B))
      boot_mode_and_bootloader_inst (.clk_i(clk), .resetn_i(resetn), .mode_entry_interrupt_pin_i(entry),
      .boot_select_high_strap_i(hi), .boot_select_low_strap_i(lo), .serial_load_pin_i(line),
      .ext_data_i(ext_data), .vec_sel_i(vec_sel), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_clk_o(bus_clk), .ext_cnt_clk_o(cclk), .ext_cnt_rst_o(crst),
      .program_indicator_pin_o(program_indicator), .verify_indicator_pin_o(verify_indicator), .vec_addr_o(vaddr),
      .start_pc_o(spc), .run_o(run));

   boot_source_model #(.BIT(BIT)) boot_source_model_inst (.clk_i(clk), .go_i(go), .byte_i(tx_byte),
      .bad_stop_i(bad), .flip_i(flip), .ext_cnt_clk_i(cclk), .ext_cnt_rst_i(crst), .line_o(line),
      .busy_o(busy), .ext_data_o(ext_data));

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task conclude;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   // Reset with straps applied; outputs checked while reset is held
   task rst(input logic e, input logic h, input logic l);
      @(posedge clk);
      resetn <= 1'b0;
      entry <= e;
      hi <= h;
      lo <= l;
      repeat (2) @(posedge clk);
      #1 chk({13'h0000, program_indicator, verify_indicator, run}, 16'h0000);
      chk(spc, START_PC);
      @(posedge clk) resetn <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
   endtask : rst

   task rd_reg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      qexp.push_back(e);
      @(posedge clk) rd <= 1'b0;
   endtask : rd_reg

   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
   endtask : wr_reg

   task vec(input logic [2:0] s, input logic [15:0] e);
      @(posedge clk) vec_sel <= s;
      repeat (2) @(posedge clk);
      #1 chk(vaddr, e);
   endtask : vec

   task send(input logic [7:0] b, input logic bs);
      @(posedge clk);
      tx_byte <= b;
      bad <= bs;
      go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
      repeat (BIT) @(posedge clk);
   endtask : send

   task wait_run;
      for (int n = 0; n < 5000 && run !== 1'b1; n++) @(posedge clk);
      #1;
      chk({15'h0000, run}, 16'h0001);
   endtask : wait_run

   // Read data monitor: compares the cycle after each read strobe
   always @(posedge clk)
   begin
      if (rd_seen) chk({8'h00, rdata}, {8'h00, qexp.pop_front()});
      rd_seen <= rd;
   end

   initial
   begin
      repeat (30000) @(posedge clk);
      err_total++;
      conclude();
   end

   initial
   begin
      rst(1'b0, 1'b1, 1'b1);
      rd_reg(REG_STATUS, 8'h00);
      rd_reg(REG_OPCODE, JUMP_OPCODE);
      rd_reg(REG_SETTLE, SETTLE_RESET);
      rd_reg(4'hF, 8'h00);
      wr_reg(REG_SETTLE, 8'h02);
      rd_reg(REG_SETTLE, 8'h02);
      for (int s = 0; s < 6; s++) vec(3'(s), 16'h3FFE - 16'(2 * s));
      @(posedge clk) #1 b0 = bus_clk;
      @(posedge clk) #1 chk({15'h0000, bus_clk}, {15'h0000, ~b0});
      $display("single chip test done");

      rst(1'b1, 1'b1, 1'b0);
      chk(spc, START_PC);
      chk({15'h0000, run}, 16'h0001);
      for (int s = 0; s < 5; s++) vec(3'(s), PSEUDO_VEC_BASE + 16'(3 * s));
      vec(VEC_RESET, START_PC);
      $display("ram jump test done");

      rst(1'b1, 1'b1, 1'b1);
      a_b = 8'($random(seed));
      b_b = 8'($random(seed));
      send(8'h55, 1'b1);
      send(8'h03, 1'b0);
      send(a_b, 1'b0);
      chk({15'h0000, run}, 16'h0000);
      send(b_b, 1'b0);
      chk({15'h0000, run}, 16'h0001);
      chk(spc, START_PC);
      send(8'hAA, 1'b0);
      rd_reg(REG_STATUS, 8'h34);
      rd_reg(REG_COUNT, 8'h03);
      wr_reg(REG_RAM_PTR, 8'h01);
      rd_reg(REG_RAM_DATA, a_b);
      rd_reg(REG_RAM_DATA, b_b);
      rd_reg(REG_RAM_PTR, 8'h03);
      $display("ram load test done");

      rst(1'b1, 1'b0, 1'b1);
      repeat (4) @(posedge clk);
      #1 chk({15'h0000, program_indicator}, 16'h0001);
      chk({15'h0000, run}, 16'h0000);
      rst(1'b1, 1'b0, 1'b1);
      #1 chk({15'h0000, program_indicator}, 16'h0001);
      wait_run();
      chk({14'h0000, program_indicator, verify_indicator}, 16'h0001);
      chk({8'h00, ext_data}, 16'h0085);
      rd_reg(REG_STATUS, 8'h4A);
      chk(spc, 16'h3FE4);
      vec(VEC_SWI, 16'h3FEE);
      vec(VEC_IRQ, 16'h3FEC);
      $display("program and verify test done");

      @(posedge clk) flip <= 1'b1;
      rst(1'b1, 1'b0, 1'b0);
      wait_run();
      chk({14'h0000, program_indicator, verify_indicator}, 16'h0000);
      rd_reg(REG_STATUS, 8'h09);
      repeat (2) @(posedge clk);
      $display("verify mismatch test done");
      conclude();
   end
endmodule : boot_mode_and_bootloader_tb
